/* shared/power_event_pkg.sv */
// Purpose: constants and carriers for the power event register slice
// Assumes: 32-bit AHB-Lite register bus, byte addresses as printed
// Notes: event bit positions within the enable words are parameters here
package power_event_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_POF_FLAG = 12'h108;
  localparam logic [11:0] OFS_ENTRY_FLAG = 12'h114;
  localparam logic [11:0] OFS_EXIT_FLAG = 12'h118;
  localparam logic [11:0] OFS_PUBLISH = 12'h198;
  localparam logic [11:0] OFS_IRQ_EN = 12'h300;
  localparam logic [11:0] OFS_IRQ_EN_SET = 12'h304;
  localparam logic [11:0] OFS_IRQ_EN_CLR = 12'h308;
  localparam logic [11:0] OFS_STATUS = 12'h310;

  // field positions
  localparam int BIT_POF = 0;
  localparam int BIT_ENTRY = 5;
  localparam int BIT_EXIT = 6;
  localparam int CHAN_IDX_W = 16;
  localparam int PUB_EN_BIT = 31;
  localparam int NUM_EV = 3;

  // reset values
  localparam logic [31:0] RST_PUBLISH = 32'h0000_0000;
  localparam logic [NUM_EV-1:0] RST_EV = 3'h0;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  // internal event order: 0 power-fail warning, 1 sleep entry, 2 sleep exit
  typedef struct packed {
    logic cpu_sleep_exit_event;
    logic cpu_sleep_entry_event;
    logic power_fail_warning_event;
  } power_events_t;

  typedef struct packed {
    logic valid;
    logic [CHAN_IDX_W-1:0] channel_index;
  } publish_out_t;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_WAIT = 1'b1
  } bus_state_t;

endpackage : power_event_pkg

/* src/sticky_flag_bank.sv */
// Purpose: sticky event flags with write-one-to-clear
// Assumes: set and clear are one-cycle strobes on hclk
// Notes: a set in the same cycle as its clear wins
module sticky_flag_bank #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // strobes
  input wire logic [WIDTH-1:0] set,
  input wire logic [WIDTH-1:0] clr,
  // state
  output logic [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] flags_q;
  logic [WIDTH-1:0] flags_d;

  always_comb begin
    flags_d = (flags_q & ~clr) | set;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;

  chk_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    (set != '0) |=> ((flags_q & $past(set)) == $past(set)))
    else $error("event lost against clear");
endmodule : sticky_flag_bank

/* src/power_event_irq_publish_regs.sv */
// Purpose: sleep-exit publish config and power event interrupt enables
// Assumes: AHB-Lite single word transfers, one wait state each
// Notes: events are one-cycle pulses from the power controller
module power_event_irq_publish_regs
  import power_event_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic [1:0] hresp,
  // power events in
  input wire power_event_pkg::power_events_t events,
  // interconnect and interrupt out
  output power_event_pkg::publish_out_t publish,
  output logic irq
);
  import power_event_pkg::*;

  // spread internal event bits onto their register positions
  function automatic logic [31:0] to_word(input logic [NUM_EV-1:0] v);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[BIT_POF] = v[0];
    w[BIT_ENTRY] = v[1];
    w[BIT_EXIT] = v[2];
    return w;
  endfunction : to_word

  function automatic logic [NUM_EV-1:0] from_word(input logic [31:0] w);
    return {w[BIT_EXIT], w[BIT_ENTRY], w[BIT_POF]};
  endfunction : from_word

  // bus state
  bus_state_t state_q, state_d;
  logic [11:0] addr_q, addr_d;
  logic write_q, write_d;
  logic ready_q, ready_d;
  logic [31:0] rdata_q, rdata_d;

  // register state
  logic [31:0] publish_cfg_q, publish_cfg_d;
  logic [NUM_EV-1:0] irq_en_q, irq_en_d;
  publish_out_t publish_q, publish_d;
  logic irq_q, irq_d;

  logic [NUM_EV-1:0] status;
  logic [NUM_EV-1:0] status_clr;
  logic accept;
  logic wr_fire;
  logic rd_fire;

  assign accept = hsel && (htrans == HTRANS_NONSEQ) && hready && ready_q;
  assign wr_fire = (state_q == BUS_WAIT) && write_q;
  assign rd_fire = (state_q == BUS_WAIT) && !write_q;

  // one wait state keeps a read behind any earlier write
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    write_d = write_q;
    ready_d = ready_q;
    rdata_d = rdata_q;
    unique case (state_q)
      BUS_IDLE: begin
        if (accept) begin
          state_d = BUS_WAIT;
          addr_d = {haddr[11:2], 2'b00};
          write_d = hwrite;
          ready_d = 1'b0;
        end
      end
      BUS_WAIT: begin
        state_d = BUS_IDLE;
        ready_d = 1'b1;
        rdata_d = 32'h0000_0000;
        if (!write_q) begin
          unique case (addr_q)
            OFS_POF_FLAG: rdata_d = {31'h0, status[0]};
            OFS_ENTRY_FLAG: rdata_d = {31'h0, status[1]};
            OFS_EXIT_FLAG: rdata_d = {31'h0, status[2]};
            OFS_PUBLISH: rdata_d = publish_cfg_q;
            OFS_IRQ_EN, OFS_IRQ_EN_SET, OFS_IRQ_EN_CLR: rdata_d = to_word(irq_en_q);
            OFS_STATUS: rdata_d = to_word(status);
            default: rdata_d = 32'h0000_0000;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= BUS_IDLE;
      addr_q <= 12'h000;
      write_q <= 1'b0;
      ready_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      write_q <= write_d;
      ready_q <= ready_d;
      rdata_q <= rdata_d;
    end
  end

  // register writes, publishing and interrupt
  always_comb begin
    publish_cfg_d = publish_cfg_q;
    irq_en_d = irq_en_q;
    status_clr = '0;
    if (wr_fire) begin
      unique case (addr_q)
        OFS_PUBLISH: begin
          publish_cfg_d = 32'h0000_0000;
          publish_cfg_d[CHAN_IDX_W-1:0] = hwdata[CHAN_IDX_W-1:0];
          publish_cfg_d[PUB_EN_BIT] = hwdata[PUB_EN_BIT];
        end
        OFS_IRQ_EN: irq_en_d = from_word(hwdata);
        OFS_IRQ_EN_SET: irq_en_d = irq_en_q | from_word(hwdata);
        OFS_IRQ_EN_CLR: irq_en_d = irq_en_q & ~from_word(hwdata);
        OFS_STATUS: status_clr = from_word(hwdata);
        default: ;
      endcase
    end
    publish_d.valid = events.cpu_sleep_exit_event && publish_cfg_q[PUB_EN_BIT];
    publish_d.channel_index = publish_cfg_q[CHAN_IDX_W-1:0];
    irq_d = |(status & irq_en_q);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      publish_cfg_q <= RST_PUBLISH;
      irq_en_q <= RST_EV;
      publish_q <= '0;
      irq_q <= 1'b0;
    end else begin
      publish_cfg_q <= publish_cfg_d;
      irq_en_q <= irq_en_d;
      publish_q <= publish_d;
      irq_q <= irq_d;
    end
  end

  sticky_flag_bank #(
    .WIDTH(NUM_EV)
  ) u_status (
    .hclk(hclk),
    .hresetn(hresetn),
    .set(events),
    .clr(status_clr),
    .flags(status)
  );

  assign hreadyout = ready_q;
  assign hrdata = rdata_q;
  assign hresp = HRESP_OKAY;
  assign publish = publish_q;
  assign irq = irq_q;

  // checks
  sequence s_accept;
    hsel && (htrans == HTRANS_NONSEQ) && hready && hreadyout;
  endsequence

  sequence s_wait_then_ready;
    !hreadyout ##1 hreadyout;
  endsequence

  chk_bus_one_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    s_accept |=> s_wait_then_ready)
    else $error("transfer not answered after one wait state");

  chk_publish_fires: assert property (@(posedge hclk) disable iff (!hresetn)
    (events.cpu_sleep_exit_event && publish_cfg_q[PUB_EN_BIT])
      |=> (publish.valid && publish.channel_index == $past(publish_cfg_q[CHAN_IDX_W-1:0])))
    else $error("sleep exit not published on chosen channel");

  chk_publish_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    (!publish_cfg_q[PUB_EN_BIT] || !events.cpu_sleep_exit_event) |=> !publish.valid)
    else $error("publish seen while disabled");

  chk_event_interrupt_enable_write: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_fire && addr_q == OFS_IRQ_EN) |=> (irq_en_q == $past(from_word(hwdata))))
    else $error("enable write not stored");

  chk_set_only_ones: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_fire && addr_q == OFS_IRQ_EN_SET) |=> (irq_en_q == ($past(irq_en_q) | $past(from_word(hwdata)))))
    else $error("set-enable did not or in ones");

  chk_set_read_back: assert property (@(posedge hclk) disable iff (!hresetn)
    (rd_fire && addr_q == OFS_IRQ_EN_SET) |=> (hrdata == to_word($past(irq_en_q)) && hreadyout))
    else $error("set-enable read mismatch");

  chk_clear_off: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr_fire && addr_q == OFS_IRQ_EN_CLR) |=> ((irq_en_q & $past(from_word(hwdata))) == '0))
    else $error("clear-enable left a bit on");

  chk_entry_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    events.cpu_sleep_entry_event |=> status[1])
    else $error("sleep entry flag not set");

  chk_irq_raise: assert property (@(posedge hclk) disable iff (!hresetn)
    (events.power_fail_warning_event && irq_en_q[0] && !wr_fire) |-> ##[1:2] irq)
    else $error("enabled event raised no interrupt");

  chk_irq_blocked: assert property (@(posedge hclk) disable iff (!hresetn)
    (irq_en_q == '0 && $past(irq_en_q) == '0) |=> !irq)
    else $error("interrupt with all enables off");
endmodule : power_event_irq_publish_regs

/* dv/power_event_irq_publish_regs_bench.sv */
// Purpose: self-checking bench for the power event register slice
// Assumes: one wait state per transfer, hready fed back from hreadyout
// Notes: event pulses are one cycle wide, driven on the rising edge
module power_event_irq_publish_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import power_event_pkg::*;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout;
  logic [31:0] hrdata;
  logic [1:0] hresp;
  power_events_t events = power_events_t'(3'h0);
  publish_out_t publish;
  logic irq;
  int err_count = 0;
  int checks = 0;

  always #2.5 hclk = ~hclk;

  power_event_irq_publish_regs i_power_event_irq_publish_regs (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .events(events),
    .publish(publish), .irq(irq)
  );

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check

  // sample ready before the edge so the design's own update cannot race us
  // no cycle limit here: a hang is ended by the watchdog
  task wait_rdy(output logic [31:0] d);
    @(negedge hclk);
    while (hreadyout !== 1'b1) begin
      @(negedge hclk);
    end
    d = hrdata;
    @(posedge hclk);
  endtask : wait_rdy

  task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_rdy(rd);
    // select only qualifies the address phase; dropping it here keeps back-to-back calls clean
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(rd);
    check("hresp", {30'h0, hresp}, {30'h0, HRESP_OKAY});
  endtask : xfer

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr

  task rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0000_0000, r);
    check(name, r, exp);
  endtask : rd_chk

  task pulse(input logic [2:0] ev, input logic exp_valid);
    @(posedge hclk);
    events <= power_events_t'(ev);
    @(posedge hclk);
    events <= power_events_t'(3'h0);
    @(negedge hclk);
    check("publish_valid", {31'h0, publish.valid}, {31'h0, exp_valid});
    @(negedge hclk);
    check("publish_valid_after", {31'h0, publish.valid}, 32'h0000_0000);
  endtask : pulse

  task t_reset;
    rd_chk("publish_rst", OFS_PUBLISH, 32'h0000_0000);
    rd_chk("enable_rst", OFS_IRQ_EN, 32'h0000_0000);
    rd_chk("set_rst", OFS_IRQ_EN_SET, 32'h0000_0000);
    rd_chk("entry_flag_idle", OFS_ENTRY_FLAG, 32'h0000_0000);
    check("irq_rst", {31'h0, irq}, 32'h0000_0000);
  endtask : t_reset

  task t_publish;
    wr(OFS_PUBLISH, 32'h0000_A5C3);
    rd_chk("publish_cfg", OFS_PUBLISH, 32'h0000_A5C3);
    pulse(3'h4, 1'b0);
    check("channel", {16'h0, publish.channel_index}, 32'h0000_A5C3);
    wr(OFS_PUBLISH, 32'h8000_5A3C);
    pulse(3'h4, 1'b1);
    check("channel_new", {16'h0, publish.channel_index}, 32'h0000_5A3C);
  endtask : t_publish

  task t_enables;
    wr(OFS_IRQ_EN, 32'hFFFF_FFFF);
    rd_chk("enable_all", OFS_IRQ_EN, 32'h0000_0061);
    rd_chk("set_view", OFS_IRQ_EN_SET, 32'h0000_0061);
    wr(OFS_IRQ_EN, 32'h0000_0000);
    rd_chk("enable_none", OFS_IRQ_EN, 32'h0000_0000);
    wr(OFS_IRQ_EN_SET, 32'h0000_0001);
    rd_chk("set_one", OFS_IRQ_EN_SET, 32'h0000_0001);
    wr(OFS_IRQ_EN_SET, 32'h0000_0040);
    rd_chk("set_keep", OFS_IRQ_EN, 32'h0000_0041);
    wr(OFS_IRQ_EN_CLR, 32'h0000_0001);
    rd_chk("clear_one", OFS_IRQ_EN_CLR, 32'h0000_0040);
  endtask : t_enables

  task t_irq;
    pulse(3'h4, 1'b1);
    repeat (2) @(negedge hclk);
    check("irq_exit", {31'h0, irq}, 32'h0000_0001);
    rd_chk("status", OFS_STATUS, 32'h0000_0040);
    wr(OFS_STATUS, 32'h0000_0040);
    repeat (2) @(negedge hclk);
    check("irq_cleared", {31'h0, irq}, 32'h0000_0000);
    wr(OFS_IRQ_EN_CLR, 32'h0000_0040);
    pulse(3'h2, 1'b0);
    pulse(3'h1, 1'b0);
    rd_chk("entry_flag", OFS_ENTRY_FLAG, 32'h0000_0001);
    check("irq_masked", {31'h0, irq}, 32'h0000_0000);
    wr(OFS_ENTRY_FLAG, 32'h0000_0000);
    rd_chk("entry_flag_kept", OFS_ENTRY_FLAG, 32'h0000_0001);
    wr(OFS_IRQ_EN_SET, 32'h0000_0020);
    repeat (2) @(negedge hclk);
    check("irq_entry", {31'h0, irq}, 32'h0000_0001);
    rd_chk("unmapped", 12'h400, 32'h0000_0000);
  endtask : t_irq

  task summarize;
    $display("checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_publish();
    t_enables();
    t_irq();
    summarize();
  end

  // whole run is about a hundred cycles
  initial begin
    repeat (3000) @(posedge hclk);
    err_count++;
    summarize();
  end

endmodule : power_event_irq_publish_regs_bench
